//--- bench/swmap_far_model.sv
`timescale 1ns/1ns
module swmap_far_model (
	input wire logic i_clk_sys,
	input wire logic i_lock_on,
	input wire logic i_width_on,
	input wire logic i_width_12,
	input wire logic i_addr_on,
	input wire logic [6:0] i_addr,
	output logic o_rx_lock,
	output logic o_bc_width_valid,
	output logic o_bc_width_12,
	output logic o_bc_addr_valid,
	output logic [6:0] o_bc_des_addr
);
	logic [6:0] junk_ff;
	initial begin
		{o_rx_lock, o_bc_width_valid, o_bc_width_12, o_bc_addr_valid} = 4'h0;
		o_bc_des_addr = 7'h2A;
		junk_ff = 7'h55;
	end
	// unannounced lines churn so a stale value is never mistaken for data
	always @(posedge i_clk_sys) begin
		junk_ff <= ~junk_ff + 7'h13;
		o_rx_lock <= i_lock_on;
		o_bc_width_valid <= i_lock_on && i_width_on;
		o_bc_width_12 <= (i_lock_on && i_width_on) ? i_width_12 : junk_ff[0];
		o_bc_addr_valid <= i_lock_on && i_addr_on;
		o_bc_des_addr <= (i_lock_on && i_addr_on) ? i_addr : junk_ff;
	end
endmodule // swmap_far_model

//--- bench/swmap_top_test.sv
`timescale 1ns/1ns
module swmap_top_test;
	import swmap_pkg::*;
	logic clk = 0, rst = 1, rd = 0, wr = 0, req = 0;
	logic lock_on = 0, width_on = 0, width_12 = 0, addr_on = 0;
	logic [7:0] adr = 8'h00, q;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] be = 4'hF;
	logic [6:0] req_addr = 7'h00, far_addr = 7'h00, ra, tla;
	logic [1:0] resp;
	logic wait_rq, lock, bwv, bw12, bav, fv, fb;
	logic [6:0] bda;
	swmap_addr_t fa;
	swmap_width_t txw;
	int bad_count = 0, checks_done = 0;
	logic [7:0] mdl [int];
	swmap_far_model far_u (.i_clk_sys(clk), .i_lock_on(lock_on), .i_width_on(width_on),
		.i_width_12(width_12), .i_addr_on(addr_on), .i_addr(far_addr), .o_rx_lock(lock),
		.o_bc_width_valid(bwv), .o_bc_width_12(bw12), .o_bc_addr_valid(bav),
		.o_bc_des_addr(bda));
	swmap_top dut_u (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .o_avs_response(resp),
		.i_rx_lock(lock), .i_bc_width_valid(bwv), .i_bc_width_12(bw12),
		.i_bc_addr_valid(bav), .i_bc_des_addr(bda), .i_i2c_req_valid(req),
		.i_i2c_req_addr(req_addr), .o_tx_width(txw), .o_fwd_valid(fv), .o_fwd_addr(fa),
		.o_fwd_blocked(fb));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic int exp_width();
		logic [7:0] w;
		w = mdl[8'h14];
		if (w[5])
			return w[1] ? 12 : (w[0] ? 10 : 0);
		return (lock_on && width_on) ? (width_12 ? 12 : 10) : 0;
	endfunction
	function automatic logic [7:0] exp_reg(input logic [7:0] a);
		logic [7:0] w;
		w = mdl[8'h14];
		if (a == 8'h14)
			return {2'b00, w[5], lock_on && width_on, exp_width() == 12, exp_width() == 10, w[1:0]};
		if (a == 8'h18 && lock_on && addr_on && !mdl[8'h18][0])
			return {far_addr, 1'b0};
		return mdl.exists(a) ? mdl[a] : 8'h00;
	endfunction
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] m);
		int n;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h0, d};
		be <= m;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (wait_rq === 1'b0)
				break;
		end
		if (n == 20) begin
			chk("waitrequest", 1, 0);
			finish_test;
		end
		q = rdata[7:0];
		chk("response", resp, mdl.exists(a) ? 2'b00 : 2'b10);
		if (w && m[0] && mdl.exists(a))
			mdl[a] = (a == 8'h14) ? (d & 8'h23) : d;
		wr <= 0;
		rd <= 0;
	endtask
	task automatic rd_chk(input logic [7:0] a);
		for (int n = 0; n < 12; n++) begin
			bus(0, a, 8'h00, 4'hF);
			if (q === exp_reg(a))
				break;
		end
		chk("register", q, exp_reg(a));
	endtask
	task automatic wait_width();
		swmap_width_t e;
		e = exp_width() == 12 ? SWMAP_W_TWELVE : (exp_width() == 10 ? SWMAP_W_TEN : SWMAP_W_NONE);
		for (int n = 0; n < 12 && txw !== e; n++)
			@(posedge clk);
		chk("tx width", txw, e);
	endtask
	task automatic i2c(input logic [6:0] a);
		logic [6:0] e;
		e = 7'h00;
		if (mdl[8'h40][0] && a == mdl[8'h1C][7:1] && a != 0)
			e = exp_reg(8'h18)[7:1];
		else if (mdl[8'h40][0] && a == mdl[8'h24][7:1] && a != 0)
			e = mdl[8'h20][7:1];
		@(posedge clk);
		req <= 1;
		req_addr <= a;
		@(posedge clk);
		req <= 0;
		@(negedge clk);
		chk("fwd valid", fv, e != 0);
		chk("fwd blocked", fb, e == 0);
		if (e != 0)
			chk("fwd addr", fa, e);
	endtask
	initial begin
		void'($urandom(37));
		mdl[8'h14] = 0;
		mdl[8'h18] = 0;
		mdl[8'h1C] = 0;
		mdl[8'h20] = 0;
		mdl[8'h24] = 0;
		mdl[8'h40] = 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		foreach (mdl[a]) rd_chk(a[7:0]);
		rd_chk(8'h30);
		bus(1, 8'h1C, 8'hFE, 4'h0);
		rd_chk(8'h1C);
		// force twelve then ten; each write keeps the other select bit clear
		for (int f = 2; f >= 1; f--) begin
			bus(1, 8'h14, 8'h20 | f[7:0], 4'hF);
			wait_width();
			rd_chk(8'h14);
		end
		lock_on <= 1;
		width_on <= 1;
		width_12 <= 1;
		repeat (8) @(posedge clk);
		wait_width();
		rd_chk(8'h14);
		bus(1, 8'h14, 8'h02, 4'hF);
		for (int b = 0; b < 2; b++) begin
			width_12 <= b[0];
			repeat (8) @(posedge clk);
			wait_width();
			rd_chk(8'h14);
		end
		far_addr <= 7'(($urandom % 126) + 1);
		addr_on <= 1;
		repeat (2) @(posedge clk);
		rd_chk(8'h18);
		// software address written with hold set, so the channel cannot replace it
		bus(1, 8'h18, {7'(($urandom % 126) + 1), 1'b1}, 4'hF);
		far_addr <= ~far_addr;
		repeat (8) @(posedge clk);
		rd_chk(8'h18);
		ra = 7'(($urandom % 63) + 1);
		tla = ra + 7'h40;
		bus(1, 8'h1C, {ra, 1'b0}, 4'hF);
		bus(1, 8'h20, {7'(($urandom % 126) + 1), 1'b0}, 4'hF);
		bus(1, 8'h24, {tla, 1'b0}, 4'hF);
		i2c(ra);
		i2c(tla);
		bus(1, 8'h40, 8'h00, 4'hF);
		i2c(ra);
		i2c(tla);
		bus(1, 8'h40, 8'h01, 4'hF);
		bus(1, 8'h20, 8'h00, 4'hF);
		i2c(tla);
		bus(1, 8'h18, 8'h01, 4'hF);
		i2c(ra);
		finish_test;
	end
endmodule // swmap_top_test

//--- hw/swmap_pkg.sv
package swmap_pkg;
	typedef enum logic [1:0] {SWMAP_W_NONE, SWMAP_W_TEN, SWMAP_W_TWELVE} swmap_width_t;
	typedef logic [6:0] swmap_addr_t;
endpackage

//--- hw/swmap_regs.svh
`ifndef SWMAP_REGS_SVH
`define SWMAP_REGS_SVH
// register offsets, printed offsets are register indices; byte address = 4 * index
`define SWMAP_IDX_WIDTH_SEL 8'h05
`define SWMAP_IDX_REMOTE_ID 8'h06
`define SWMAP_IDX_DES_ALIAS 8'h07
`define SWMAP_IDX_TARGET_ID 8'h08
`define SWMAP_IDX_TARGET_ALIAS 8'h09
`define SWMAP_IDX_CONTROL 8'h10
// width select fields
`define SWMAP_BIT_OVERRIDE 5
`define SWMAP_BIT_CURRENT 4
`define SWMAP_BIT_IS12 3
`define SWMAP_BIT_IS10 2
`define SWMAP_BIT_F12 1
`define SWMAP_BIT_F10 0
// remote id hold bit
`define SWMAP_BIT_HOLD 0
// control register pass-through enable
`define SWMAP_BIT_PASS 0
`define SWMAP_RST_BYTE 8'h00
`define SWMAP_RST_PASS 1'b1
`endif

//--- hw/swmap_remap.sv
`timescale 1ns/1ns
`include "swmap_regs.svh"
module swmap_remap (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_req_valid,
	input wire swmap_pkg::swmap_addr_t i_req_addr,
	input wire logic i_pass_en,
	input wire swmap_pkg::swmap_addr_t i_des_alias,
	input wire swmap_pkg::swmap_addr_t i_des_addr,
	input wire swmap_pkg::swmap_addr_t i_tgt_alias,
	input wire swmap_pkg::swmap_addr_t i_tgt_addr,
	output logic o_fwd_valid,
	output swmap_pkg::swmap_addr_t o_fwd_addr,
	output logic o_blocked
);
	import swmap_pkg::*;
	typedef struct packed {
		logic fwd_valid;
		swmap_addr_t fwd_addr;
		logic blocked;
	} swmap_remap_t;
	swmap_remap_t state_ff;
	swmap_remap_t nxt_state;
	// zero alias or zero physical address means no match, so no access
	function automatic logic hit(input swmap_addr_t addr, input swmap_addr_t alias_a,
		input swmap_addr_t phys);
		hit = (alias_a != 7'h00) && (phys != 7'h00) && (addr == alias_a);
	endfunction
	logic des_hit;
	logic tgt_hit;
	always_comb begin
		des_hit = i_pass_en && hit(i_req_addr, i_des_alias, i_des_addr);
		tgt_hit = i_pass_en && hit(i_req_addr, i_tgt_alias, i_tgt_addr);
		nxt_state.fwd_valid = 1'b0;
		nxt_state.fwd_addr = state_ff.fwd_addr;
		nxt_state.blocked = 1'b0;
		if (i_req_valid) begin
			if (des_hit) begin
				nxt_state.fwd_valid = 1'b1;
				nxt_state.fwd_addr = i_des_addr;
			end else if (tgt_hit) begin
				nxt_state.fwd_valid = 1'b1;
				nxt_state.fwd_addr = i_tgt_addr;
			end else begin
				nxt_state.blocked = 1'b1;
			end
		end
		if (i_rst) begin
			nxt_state = '0;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		state_ff <= nxt_state;
	end
	assign o_fwd_valid = state_ff.fwd_valid;
	assign o_fwd_addr = state_ff.fwd_addr;
	assign o_blocked = state_ff.blocked;

	a_des_zero_block: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_req_valid && i_des_addr == 7'h00 && i_tgt_alias == 7'h00) |=> !o_fwd_valid)
		else $error("forward with zero remote address");
	a_alias_remap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_req_valid && i_pass_en && i_des_alias != 7'h00 && i_des_addr != 7'h00
		&& i_req_addr == i_des_alias) |=> (o_fwd_valid && o_fwd_addr == $past(i_des_addr)))
		else $error("alias hit not remapped");
	a_target_remap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_req_valid && i_pass_en && i_tgt_alias != 7'h00 && i_tgt_addr != 7'h00
		&& i_req_addr == i_tgt_alias && i_req_addr != i_des_alias)
		|=> (o_fwd_valid && o_fwd_addr == $past(i_tgt_addr)))
		else $error("target alias not remapped");
	a_pass_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_req_valid && !i_pass_en) |=> (!o_fwd_valid && o_blocked))
		else $error("forward while pass-through off");
endmodule // swmap_remap

//--- hw/swmap_sync.sv
`timescale 1ns/1ns
module swmap_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_sync
);
	typedef struct packed {
		logic meta;
		logic stable;
	} swmap_sync_t;
	swmap_sync_t state_ff;
	swmap_sync_t nxt_state;
	always_comb begin
		nxt_state.meta = i_async;
		nxt_state.stable = state_ff.meta;
		if (i_rst) begin
			nxt_state = '0;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		state_ff <= nxt_state;
	end
	assign o_sync = state_ff.stable;
endmodule // swmap_sync

//--- hw/swmap_top.sv
`timescale 1ns/1ns
`include "swmap_regs.svh"
// Behaviour
// - with override set, transmit width comes from local select bits, not back channel
// - status bit 4 reads 1 when remote width selection is current
// - bit 3 flags 12-bit operation, bit 2 flags 10-bit operation
// - twelve-bit select forces 12-bit width only while override is set
// - ten-bit select forces 10-bit width only while override is set
// - remote address in bits 7:1, resets to zero; zero blocks remote access
// - after receive lock, remote address loads from control channel unless held
// - hold bit set blocks automatic reload and keeps written address
// - deserializer alias hits are remapped to remote address; zero alias disables
// - target alias hits are remapped to target address; zero address disables
// - alias decoding only while pass-through enable is set, set after reset
// - separate 7-bit target alias register configures target decoder
module swmap_top (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [1:0] o_avs_response,
	input wire logic i_rx_lock,
	input wire logic i_bc_width_valid,
	input wire logic i_bc_width_12,
	input wire logic i_bc_addr_valid,
	input wire swmap_pkg::swmap_addr_t i_bc_des_addr,
	input wire logic i_i2c_req_valid,
	input wire swmap_pkg::swmap_addr_t i_i2c_req_addr,
	output swmap_pkg::swmap_width_t o_tx_width,
	output logic o_fwd_valid,
	output swmap_pkg::swmap_addr_t o_fwd_addr,
	output logic o_fwd_blocked
);
	import swmap_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [1:0] resp;
		logic override;
		logic force12;
		logic force10;
		logic remote_current;
		logic remote12;
		swmap_addr_t des_addr;
		logic hold;
		swmap_addr_t des_alias;
		logic des_alias_b0;
		swmap_addr_t tgt_addr;
		logic tgt_addr_b0;
		swmap_addr_t tgt_alias;
		logic tgt_alias_b0;
		logic pass_en;
		swmap_width_t width;
	} swmap_state_t;

	swmap_state_t state_ff;
	swmap_state_t nxt_state;

	// link-side levels come from another clock, so they are synchronised
	logic lock_s;
	logic bc_wvalid_s;
	logic bc_w12_s;
	logic bc_avalid_s;
	logic [2:0] sync_in;
	logic [2:0] sync_out;
	assign sync_in = {i_bc_width_valid, i_bc_width_12, i_bc_addr_valid};

	swmap_sync u_sync_lock (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_async(i_rx_lock),
		.o_sync(lock_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			swmap_sync u_sync (
				.i_clk_sys(i_clk_sys),
				.i_rst(i_rst),
				.i_async(sync_in[gi]),
				.o_sync(sync_out[gi])
			);
		end
	endgenerate
	assign bc_wvalid_s = sync_out[2];
	assign bc_w12_s = sync_out[1];
	assign bc_avalid_s = sync_out[0];
	// address bus is only sampled while its synchronised valid stands, so it is
	// quasi-static; the sender must hold it stable while valid is high

	// word index decode; byte address is four times the register index
	function automatic logic idx_hit(input logic [7:0] addr, input logic [7:0] idx);
		idx_hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx[5:0]);
	endfunction

	logic wr_lane0;
	logic access;
	assign access = (i_avs_read || i_avs_write) && !state_ff.ack;
	assign wr_lane0 = access && i_avs_write && i_avs_byteenable[0];

	function automatic logic [7:0] width_byte(input swmap_state_t s);
		width_byte = 8'h00;
		width_byte[`SWMAP_BIT_OVERRIDE] = s.override;
		width_byte[`SWMAP_BIT_CURRENT] = s.remote_current;
		width_byte[`SWMAP_BIT_IS12] = (s.width == SWMAP_W_TWELVE);
		width_byte[`SWMAP_BIT_IS10] = (s.width == SWMAP_W_TEN);
		width_byte[`SWMAP_BIT_F12] = s.force12;
		width_byte[`SWMAP_BIT_F10] = s.force10;
	endfunction

	logic [7:0] rd_byte;
	logic mapped;
	logic [7:0] width_now;
	assign width_now = width_byte(state_ff);
	always_comb begin
		rd_byte = `SWMAP_RST_BYTE;
		mapped = 1'b1;
		if (idx_hit(i_avs_address, `SWMAP_IDX_WIDTH_SEL)) begin
			rd_byte = width_byte(state_ff);
		end else if (idx_hit(i_avs_address, `SWMAP_IDX_REMOTE_ID)) begin
			rd_byte = {state_ff.des_addr, state_ff.hold};
		end else if (idx_hit(i_avs_address, `SWMAP_IDX_DES_ALIAS)) begin
			rd_byte = {state_ff.des_alias, state_ff.des_alias_b0};
		end else if (idx_hit(i_avs_address, `SWMAP_IDX_TARGET_ID)) begin
			rd_byte = {state_ff.tgt_addr, state_ff.tgt_addr_b0};
		end else if (idx_hit(i_avs_address, `SWMAP_IDX_TARGET_ALIAS)) begin
			rd_byte = {state_ff.tgt_alias, state_ff.tgt_alias_b0};
		end else if (idx_hit(i_avs_address, `SWMAP_IDX_CONTROL)) begin
			rd_byte = {7'h00, state_ff.pass_en};
		end else begin
			mapped = 1'b0;
		end
	end

	logic sw_remote_wr;
	assign sw_remote_wr = wr_lane0 && idx_hit(i_avs_address, `SWMAP_IDX_REMOTE_ID);

	always_comb begin
		nxt_state = state_ff;
		// one wait cycle per access: request taken, answer on the next edge
		nxt_state.ack = access;
		nxt_state.resp = 2'b00;
		if (access) begin
			nxt_state.rdata = {24'h000000, rd_byte};
			nxt_state.resp = mapped ? 2'b00 : 2'b10;
		end
		if (wr_lane0) begin
			if (idx_hit(i_avs_address, `SWMAP_IDX_WIDTH_SEL)) begin
				nxt_state.override = i_avs_writedata[`SWMAP_BIT_OVERRIDE];
				nxt_state.force12 = i_avs_writedata[`SWMAP_BIT_F12];
				nxt_state.force10 = i_avs_writedata[`SWMAP_BIT_F10];
			end
			if (sw_remote_wr) begin
				nxt_state.des_addr = i_avs_writedata[7:1];
				nxt_state.hold = i_avs_writedata[`SWMAP_BIT_HOLD];
			end
			if (idx_hit(i_avs_address, `SWMAP_IDX_DES_ALIAS)) begin
				nxt_state.des_alias = i_avs_writedata[7:1];
				nxt_state.des_alias_b0 = i_avs_writedata[0];
			end
			if (idx_hit(i_avs_address, `SWMAP_IDX_TARGET_ID)) begin
				nxt_state.tgt_addr = i_avs_writedata[7:1];
				nxt_state.tgt_addr_b0 = i_avs_writedata[0];
			end
			if (idx_hit(i_avs_address, `SWMAP_IDX_TARGET_ALIAS)) begin
				nxt_state.tgt_alias = i_avs_writedata[7:1];
				nxt_state.tgt_alias_b0 = i_avs_writedata[0];
			end
			if (idx_hit(i_avs_address, `SWMAP_IDX_CONTROL)) begin
				nxt_state.pass_en = i_avs_writedata[`SWMAP_BIT_PASS];
			end
		end
		// a software write wins over the channel load in the same cycle, held or not;
		// a software write that sets hold in that cycle keeps its own address
		if (lock_s && bc_avalid_s && !state_ff.hold && !sw_remote_wr) begin
			nxt_state.des_addr = i_bc_des_addr;
		end
		// remote width selection is current while locked and announced
		nxt_state.remote_current = lock_s && bc_wvalid_s;
		if (lock_s && bc_wvalid_s) begin
			nxt_state.remote12 = bc_w12_s;
		end
		if (state_ff.override) begin
			// both selects set is illegal; the twelve-bit select takes priority
			if (state_ff.force12) begin
				nxt_state.width = SWMAP_W_TWELVE;
			end else if (state_ff.force10) begin
				nxt_state.width = SWMAP_W_TEN;
			end else begin
				nxt_state.width = SWMAP_W_NONE;
			end
		end else if (state_ff.remote_current) begin
			nxt_state.width = state_ff.remote12 ? SWMAP_W_TWELVE : SWMAP_W_TEN;
		end else begin
			nxt_state.width = SWMAP_W_NONE;
		end
		if (i_rst) begin
			nxt_state = '0;
			nxt_state.pass_en = `SWMAP_RST_PASS;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		state_ff <= nxt_state;
	end

	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !state_ff.ack;
	assign o_avs_readdata = state_ff.rdata;
	assign o_avs_response = state_ff.resp;
	assign o_tx_width = state_ff.width;

	swmap_remap u_remap (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_req_valid(i_i2c_req_valid),
		.i_req_addr(i_i2c_req_addr),
		.i_pass_en(state_ff.pass_en),
		.i_des_alias(state_ff.des_alias),
		.i_des_addr(state_ff.des_addr),
		.i_tgt_alias(state_ff.tgt_alias),
		.i_tgt_addr(state_ff.tgt_addr),
		.o_fwd_valid(o_fwd_valid),
		.o_fwd_addr(o_fwd_addr),
		.o_blocked(o_fwd_blocked)
	);

	sequence s_force12_set;
		state_ff.override && state_ff.force12;
	endsequence
	sequence s_width12;
		o_tx_width == SWMAP_W_TWELVE;
	endsequence

	a_override_12: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		s_force12_set |=> s_width12)
		else $error("override twelve-bit not applied");
	a_override_10: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(state_ff.override && state_ff.force10 && !state_ff.force12)
		|=> o_tx_width == SWMAP_W_TEN)
		else $error("override ten-bit not applied");
	a_follow_remote: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(!state_ff.override && state_ff.remote_current)
		|=> o_tx_width == ($past(state_ff.remote12) ? SWMAP_W_TWELVE : SWMAP_W_TEN))
		else $error("width not following remote");
	a_status_flags: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!(width_now[3] && width_now[2])
		&& (width_now[3] == (o_tx_width == SWMAP_W_TWELVE))
		&& (width_now[2] == (o_tx_width == SWMAP_W_TEN)))
		else $error("width flags disagree");
	a_current_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(lock_s && bc_wvalid_s) |=> state_ff.remote_current)
		else $error("current flag not set");
	a_auto_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(lock_s && bc_avalid_s && !state_ff.hold && !sw_remote_wr)
		|=> state_ff.des_addr == $past(i_bc_des_addr))
		else $error("remote address not loaded");
	a_hold_keeps: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(state_ff.hold && !sw_remote_wr) |=> $stable(state_ff.des_addr))
		else $error("held address changed");
	a_reset_addr: assert property (@(posedge i_clk_sys)
		i_rst |=> (state_ff.des_addr == 7'h00 && state_ff.pass_en))
		else $error("reset values wrong");
endmodule // swmap_top
